/* File: event_router_model.sv */
`timescale 1ns/1ps
module event_router_model #(
  parameter int N = 12
) (
  // clock
  input wire logic clk,
  // requests
  input wire logic [N-1:0] start_req,
  input wire logic [N-1:0] cap_req,
  input wire logic [N-1:0] cnt_req,
  // routed events
  output logic [N-1:0] start_o,
  output logic [N-1:0] cap_o,
  output logic [N-1:0] cnt_o
);
  // one flop stage, as a trigger mux output would add
  initial begin
    start_o = '0;
    cap_o = '0;
    cnt_o = '0;
  end
  always @(posedge clk) begin
    start_o <= start_req;
    cap_o <= cap_req;
    cnt_o <= cnt_req;
  end
endmodule // event_router_model

/* File: timer_pwm_block.sv */
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module timer_pwm_block #(
  parameter int NUM_WIDE = 4,
  parameter int NUM_NARROW = 8
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // avalon-mm slave
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // event inputs, one bit per channel
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] EVT_START,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] EVT_RELOAD,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] EVT_STOP,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] EVT_COUNT,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] EVT_CAPTURE,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] KILL,
  // channel outputs
  output logic [NUM_WIDE+NUM_NARROW-1:0] OVERFLOW,
  output logic [NUM_WIDE+NUM_NARROW-1:0] UNDERFLOW,
  output logic [NUM_WIDE+NUM_NARROW-1:0] CC_MATCH,
  output logic [NUM_WIDE+NUM_NARROW-1:0] PWM_OUT,
  output logic [NUM_WIDE+NUM_NARROW-1:0] PWM_OUT_N,
  // interrupt
  output logic IRQ
);
  localparam int N = NUM_WIDE + NUM_NARROW;

  if (N < 1 || N > 16) begin : g_bad_count
    $error("channel count must be 1 to 16");
  end

  // ----------------------------------------
  // bus slave: one wait state per access
  // ----------------------------------------
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] chan_rd [16];
  logic [15:0] chan_irq;
  logic [3:0] sel_chan;
  logic [3:0] sel_reg;
  logic wr_go;

  assign sel_chan = ADDRESS[9:6];
  assign sel_reg = ADDRESS[5:2];
  assign WAITREQUEST = (READ | WRITE) & ~ack_q;
  assign wr_go = WRITE & ack_q;
  assign READDATA = rdata_q;
  assign IRQ = |chan_irq;

  always_comb begin
    ack_d = WAITREQUEST;
    rdata_d = rdata_q;
    if (READ & ~ack_q) begin
      rdata_d = chan_rd[sel_chan];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_chan
    if (i >= N) begin : g_none
      // unmapped channel slots read as zero
      assign chan_rd[i] = 32'h0000_0000;
      assign chan_irq[i] = 1'b0;
    end else begin : g_live
      localparam int W = (i < NUM_WIDE) ? timer_pwm_pkg::WIDE_BITS : timer_pwm_pkg::NARROW_BITS;
      localparam logic [31:0] MSK = (W == 32) ? 32'hffff_ffff : 32'h0000_ffff;

      timer_pwm_pkg::ctrl_type ctrl_q, ctrl_d;
      timer_pwm_pkg::chan_out_type out_q, out_d;
      logic [9:0] trig_q, trig_d;
      logic [31:0] cnt_q, cnt_d, cc_q, cc_d, ccb_q, ccb_d;
      logic [31:0] per_q, per_d, perb_q, perb_d, lfsr_q, lfsr_d;
      logic ccb_new_q, ccb_new_d, perb_new_q, perb_new_d;
      logic [1:0] st_q, st_d, msk_q, msk_d;
      logic run_q, run_d, up_q, up_d, raw_q, raw_d;
      logic [7:0] pre_q, pre_d, dt_q, dt_d, pre_last;
      logic [4:0] prev_q, ev_in, fire;
      logic wr, tick, step, down, ovf, unf, cc_ev, fb, pwm, pwm_n;

      assign wr = wr_go && (sel_chan == 4'(i));
      assign ev_in = {EVT_CAPTURE[i], EVT_COUNT[i], EVT_STOP[i], EVT_RELOAD[i], EVT_START[i]};

      always_comb begin
        // event qualification per input
        for (int k = 0; k < timer_pwm_pkg::NUM_EVENTS; k++) begin
          case (timer_pwm_pkg::edge_type'(trig_q[2*k +: 2]))
            timer_pwm_pkg::EDGE_RISE: fire[k] = ev_in[k] & ~prev_q[k];
            timer_pwm_pkg::EDGE_FALL: fire[k] = ~ev_in[k] & prev_q[k];
            timer_pwm_pkg::EDGE_BOTH: fire[k] = ev_in[k] ^ prev_q[k];
            default: fire[k] = ev_in[k];
          endcase
        end
        ctrl_d = ctrl_q;
        trig_d = trig_q;
        cnt_d = cnt_q;
        cc_d = cc_q;
        ccb_d = ccb_q;
        per_d = per_q;
        perb_d = perb_q;
        ccb_new_d = ccb_new_q;
        perb_new_d = perb_new_q;
        msk_d = msk_q;
        run_d = run_q;
        up_d = up_q;
        lfsr_d = lfsr_q;
        ovf = 1'b0;
        unf = 1'b0;
        cc_ev = 1'b0;
        // prescaler: tick every 2^pre clocks
        pre_last = 8'((9'h001 << ctrl_q.pre) - 9'h001);
        tick = (pre_q == pre_last);
        pre_d = (!ctrl_q.en || tick) ? 8'h00 : pre_q + 8'h01;
        // stop takes priority over start and reload in the same cycle
        if (!ctrl_q.en || fire[2]) begin
          run_d = 1'b0;
        end else if (fire[0] || fire[1]) begin
          run_d = 1'b1;
        end
        // quadrature: count input is phase a, capture input is phase b
        if (ctrl_q.mode == timer_pwm_pkg::MODE_QUAD) begin
          step = run_q & (ev_in[3] ^ prev_q[3]);
          down = (ev_in[3] == ev_in[4]);
        end else begin
          step = run_q & tick & fire[3];
          down = (ctrl_q.dir == timer_pwm_pkg::DIR_DOWN) ||
                 (ctrl_q.dir == timer_pwm_pkg::DIR_UPDOWN && !up_q);
        end
        if (step) begin
          if (ctrl_q.dir == timer_pwm_pkg::DIR_UPDOWN && ctrl_q.mode != timer_pwm_pkg::MODE_QUAD) begin
            if (up_q && cnt_q >= per_q) begin
              up_d = 1'b0;
              cnt_d = cnt_q - 32'h0000_0001;
              ovf = 1'b1;
            end else if (!up_q && cnt_q == 32'h0000_0000) begin
              up_d = 1'b1;
              cnt_d = cnt_q + 32'h0000_0001;
              unf = 1'b1;
            end else begin
              cnt_d = up_q ? cnt_q + 32'h0000_0001 : cnt_q - 32'h0000_0001;
            end
          end else if (down) begin
            unf = (cnt_q == 32'h0000_0000);
            cnt_d = unf ? per_q : cnt_q - 32'h0000_0001;
          end else begin
            ovf = (cnt_q >= per_q);
            cnt_d = ovf ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
          end
          fb = (W == 32) ? (lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0])
                         : (lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]);
          lfsr_d = {lfsr_q[30:0], fb} & MSK;
        end else begin
          fb = 1'b0;
        end
        if (run_q && fire[1]) begin
          cnt_d = (ctrl_q.dir == timer_pwm_pkg::DIR_DOWN) ? per_q : 32'h0000_0000;
          up_d = 1'b1;
        end
        // compare or capture event
        if (ctrl_q.mode == timer_pwm_pkg::MODE_CAPTURE) begin
          if (run_q && fire[4]) begin
            cc_d = cnt_q;
            ccb_d = cc_q;
            cc_ev = 1'b1;
          end
        end else if (ctrl_q.mode != timer_pwm_pkg::MODE_QUAD) begin
          cc_ev = step && (cnt_q == cc_q);
        end
        // outside capture mode, staged values become active at terminal count
        if ((ovf || unf) && ctrl_q.mode != timer_pwm_pkg::MODE_CAPTURE) begin
          if (ccb_new_q) begin
            cc_d = ccb_q;
            ccb_d = cc_q;
            ccb_new_d = 1'b0;
          end
          if (perb_new_q) begin
            per_d = perb_q;
            perb_d = per_q;
            perb_new_d = 1'b0;
          end
        end
        // register writes other than status come last and so win over hardware updates
        if (wr) begin
          case (sel_reg)
            timer_pwm_pkg::REG_CTRL: ctrl_d = timer_pwm_pkg::ctrl_type'(WRITEDATA & 32'h00ff_07ff);
            timer_pwm_pkg::REG_TRIG: trig_d = WRITEDATA[9:0];
            timer_pwm_pkg::REG_COUNT: cnt_d = WRITEDATA;
            timer_pwm_pkg::REG_CC: cc_d = WRITEDATA;
            timer_pwm_pkg::REG_CC_BUF: begin
              ccb_d = WRITEDATA;
              ccb_new_d = 1'b1;
            end
            timer_pwm_pkg::REG_PERIOD: per_d = WRITEDATA;
            timer_pwm_pkg::REG_PERIOD_BUF: begin
              perb_d = WRITEDATA;
              perb_new_d = 1'b1;
            end
            timer_pwm_pkg::REG_MASK: msk_d = WRITEDATA[1:0];
            default: ;
          endcase
        end
        cnt_d = cnt_d & MSK;
        cc_d = cc_d & MSK;
        ccb_d = ccb_d & MSK;
        per_d = per_d & MSK;
        perb_d = perb_d & MSK;
        // sticky status, a new event beats a write-one-to-clear
        st_d = st_q & ~((wr && sel_reg == timer_pwm_pkg::REG_STATUS) ? WRITEDATA[1:0] : 2'b00);
        st_d[timer_pwm_pkg::STATUS_TC_BIT] = st_d[timer_pwm_pkg::STATUS_TC_BIT] | ovf | unf;
        st_d[timer_pwm_pkg::STATUS_CC_BIT] = st_d[timer_pwm_pkg::STATUS_CC_BIT] | cc_ev;
        // pwm waveform
        case (ctrl_q.mode)
          timer_pwm_pkg::MODE_PWM, timer_pwm_pkg::MODE_PWM_DT: raw_d = (cnt_q < cc_q);
          timer_pwm_pkg::MODE_PRPWM: raw_d = (lfsr_q < cc_q);
          default: raw_d = 1'b0;
        endcase
        // every change of level restarts the dead band
        if (raw_d != raw_q) begin
          dt_d = ctrl_q.dead;
        end else if (tick && dt_q != 8'h00) begin
          dt_d = dt_q - 8'h01;
        end else begin
          dt_d = dt_q;
        end
        if (ctrl_q.mode == timer_pwm_pkg::MODE_PWM_DT) begin
          pwm = raw_q & (dt_q == 8'h00);
          pwm_n = ~raw_q & (dt_q == 8'h00);
        end else begin
          pwm = raw_q;
          pwm_n = ~raw_q & (ctrl_q.mode != timer_pwm_pkg::MODE_COMPARE) &
                  (ctrl_q.mode != timer_pwm_pkg::MODE_CAPTURE) & (ctrl_q.mode != timer_pwm_pkg::MODE_QUAD);
        end
        out_d.ovf = ovf;
        out_d.unf = unf;
        out_d.cc = cc_ev;
        out_d.pwm = KILL[i] ? ctrl_q.kill_lvl : pwm;
        out_d.pwm_n = KILL[i] ? ctrl_q.kill_n_lvl : pwm_n;
      end

      always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
          ctrl_q <= timer_pwm_pkg::ctrl_type'(timer_pwm_pkg::CTRL_RST);
          trig_q <= timer_pwm_pkg::TRIG_RST;
          cnt_q <= 32'h0000_0000;
          cc_q <= 32'h0000_0000;
          ccb_q <= 32'h0000_0000;
          per_q <= timer_pwm_pkg::PERIOD_RST & MSK;
          perb_q <= timer_pwm_pkg::PERIOD_RST & MSK;
          lfsr_q <= timer_pwm_pkg::LFSR_RST;
          ccb_new_q <= 1'b0;
          perb_new_q <= 1'b0;
          st_q <= 2'b00;
          msk_q <= 2'b00;
          run_q <= 1'b0;
          up_q <= 1'b1;
          raw_q <= 1'b0;
          pre_q <= 8'h00;
          dt_q <= 8'h00;
          prev_q <= 5'h00;
          out_q <= '0;
        end else begin
          ctrl_q <= ctrl_d;
          trig_q <= trig_d;
          cnt_q <= cnt_d;
          cc_q <= cc_d;
          ccb_q <= ccb_d;
          per_q <= per_d;
          perb_q <= perb_d;
          lfsr_q <= lfsr_d;
          ccb_new_q <= ccb_new_d;
          perb_new_q <= perb_new_d;
          st_q <= st_d;
          msk_q <= msk_d;
          run_q <= run_d;
          up_q <= up_d;
          raw_q <= raw_d;
          pre_q <= pre_d;
          dt_q <= dt_d;
          prev_q <= ev_in;
          out_q <= out_d;
        end
      end

      always_comb begin
        case (sel_reg)
          timer_pwm_pkg::REG_CTRL: chan_rd[i] = 32'(ctrl_q);
          timer_pwm_pkg::REG_TRIG: chan_rd[i] = {22'h0, trig_q};
          timer_pwm_pkg::REG_COUNT: chan_rd[i] = cnt_q;
          timer_pwm_pkg::REG_CC: chan_rd[i] = cc_q;
          timer_pwm_pkg::REG_CC_BUF: chan_rd[i] = ccb_q;
          timer_pwm_pkg::REG_PERIOD: chan_rd[i] = per_q;
          timer_pwm_pkg::REG_PERIOD_BUF: chan_rd[i] = perb_q;
          timer_pwm_pkg::REG_STATUS: chan_rd[i] = {30'h0, st_q};
          timer_pwm_pkg::REG_MASK: chan_rd[i] = {30'h0, msk_q};
          default: chan_rd[i] = 32'h0000_0000;
        endcase
      end

      assign chan_irq[i] = |(st_q & msk_q);
      assign OVERFLOW[i] = out_q.ovf;
      assign UNDERFLOW[i] = out_q.unf;
      assign CC_MATCH[i] = out_q.cc;
      assign PWM_OUT[i] = out_q.pwm;
      assign PWM_OUT_N[i] = out_q.pwm_n;
    end
  end
endmodule // timer_pwm_block

/* File: timer_pwm_block_chk.sv */
`timescale 1ns/1ps
module timer_pwm_block_chk #(
  parameter int NUM_WIDE = 4,
  parameter int NUM_NARROW = 8
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // register bus
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // channels
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] KILL,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] OVERFLOW,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] UNDERFLOW,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] PWM_OUT,
  input wire logic [NUM_WIDE+NUM_NARROW-1:0] PWM_OUT_N,
  input wire logic IRQ
);
  // ----------------------------------------
  // first completed write since reset
  // ----------------------------------------
  logic wrote_q;
  logic wrote_d;
  always_comb begin
    wrote_d = wrote_q | (WRITE & ~WAITREQUEST);
  end
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wrote_q <= 1'b0;
    end else begin
      wrote_q <= wrote_d;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  wait_first_a: assert property ($rose(READ | WRITE) |-> WAITREQUEST)
    else $error("new request not held off");
  wait_one_a: assert property ((READ | WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("wait state longer than one cycle");
  idle_nowait_a: assert property (!(READ | WRITE) |-> !WAITREQUEST)
    else $error("wait asserted without request");
  rd_hold_a: assert property (!READ |=> $stable(READDATA))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (READ && WAITREQUEST && ADDRESS[9:6] >= 4'hc |=> READDATA == 32'h0)
    else $error("unmapped channel read not zero");
  irq_quiet_a: assert property (!wrote_q |-> !IRQ)
    else $error("interrupt with reset mask");
  idle_out_a: assert property (!wrote_q |-> (OVERFLOW | UNDERFLOW | PWM_OUT | PWM_OUT_N) == '0)
    else $error("outputs active before setup");
  kill_hold_a: assert property (KILL[2] [*4] |-> $stable(PWM_OUT[2]) && $stable(PWM_OUT_N[2]))
    else $error("outputs moved under kill");
  flow_excl_a: assert property ((OVERFLOW & UNDERFLOW) == '0)
    else $error("overflow and underflow together");
  cover property (OVERFLOW[0]);
  cover property (UNDERFLOW[0]);
  cover property ($rose(IRQ));
endmodule // timer_pwm_block_chk
bind timer_pwm_block timer_pwm_block_chk #(.NUM_WIDE(NUM_WIDE), .NUM_NARROW(NUM_NARROW)) chk (.CORE_CLK, .RSTN,
  .ADDRESS, .READ, .WRITE, .READDATA, .WAITREQUEST, .KILL, .OVERFLOW, .UNDERFLOW, .PWM_OUT, .PWM_OUT_N, .IRQ);

/* File: timer_pwm_block_tb.sv */
`timescale 1ns/1ps
module timer_pwm_block_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q;
  logic waitreq, irq;
  logic [11:0] start_req = 12'h000;
  logic [11:0] cap_req = 12'h000;
  logic [11:0] kill = 12'h000;
  logic [11:0] stop_req = 12'h000;
  logic [11:0] ev_start, ev_cap, ev_cnt, ovf, unf, ccm, pwm, pwm_n;
  logic watch_unf = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed = 88293;
  int evq[$];
  int dir, pre, per, hi, hn, hc;
  initial begin
    forever #20 clk = ~clk;
  end
  event_router_model #(.N(12)) router (.clk(clk), .start_req(start_req), .cap_req(cap_req), .cnt_req(12'hfff),
    .start_o(ev_start), .cap_o(ev_cap), .cnt_o(ev_cnt));
  timer_pwm_block #(.NUM_WIDE(4), .NUM_NARROW(8)) dut (.CORE_CLK(clk), .RSTN(rstn), .ADDRESS(address), .READ(read),
    .WRITE(write), .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(waitreq), .EVT_START(ev_start),
    .EVT_RELOAD(12'h000), .EVT_STOP(stop_req), .EVT_COUNT(ev_cnt), .EVT_CAPTURE(ev_cap), .KILL(kill),
    .OVERFLOW(ovf), .UNDERFLOW(unf), .CC_MATCH(ccm), .PWM_OUT(pwm), .PWM_OUT_N(pwm_n), .IRQ(irq));
  // ----------------------------------------
  // model side: pulse times of channel 0
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if ((watch_unf ? unf[0] : ovf[0]) === 1'b1) begin
      evq.push_back(cyc);
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon transfer; read data lands in q
  task automatic bus(input logic w, input int ch, input logic [3:0] r, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= {4'(ch), r, 2'b00};
    wdata <= d;
    write <= w;
    read <= ~w;
    // waitrequest and read data are both taken at the same rising edge
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wait_ev(input int cnt);
    int n;
    n = 0;
    evq.delete();
    while (evq.size() < cnt && n < 12000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 12000) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic kick(input int ch);
    start_req[ch] <= 1'b1;
    @(posedge clk);
    start_req[ch] <= 1'b0;
  endtask
  task automatic pwm_cnt(input int ch);
    hi = 0;
    hn = 0;
    hc = 0;
    repeat (10) begin
      @(negedge clk);
      hi += (pwm[ch] === 1'b1);
      hn += (pwm_n[ch] === 1'b1);
      hc += (ccm[ch] === 1'b1);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    bus(0, 0, timer_pwm_pkg::REG_CTRL, 0);
    check(q, timer_pwm_pkg::CTRL_RST);
    bus(0, 0, timer_pwm_pkg::REG_TRIG, 0);
    check(q, {22'h0, timer_pwm_pkg::TRIG_RST});
    bus(0, 0, timer_pwm_pkg::REG_PERIOD, 0);
    check(q, 32'hffff_ffff);
    bus(0, 4, timer_pwm_pkg::REG_PERIOD, 0);
    check(q, 32'h0000_ffff);
    bus(1, 4, timer_pwm_pkg::REG_CC, 32'h1234_5678);
    bus(0, 4, timer_pwm_pkg::REG_CC, 0);
    check(q, 32'h0000_5678);
    bus(0, 12, timer_pwm_pkg::REG_CTRL, 0);
    check(q, 32'h0);
    for (int m = 0; m < 6; m++) begin
      bus(1, 1, timer_pwm_pkg::REG_CTRL, m);
      bus(0, 1, timer_pwm_pkg::REG_CTRL, 0);
      check(q & 32'h7, m);
    end
    // interval between terminal counts per direction and prescale
    for (int i = 0; i < 4; i++) begin
      dir = i % 3;
      pre = (i == 3) ? 7 : ($random(seed) & 3);
      per = 2 + ($random(seed) & 7);
      watch_unf <= (dir == 1);
      bus(1, 0, timer_pwm_pkg::REG_CTRL, 0);
      bus(1, 0, timer_pwm_pkg::REG_PERIOD, per);
      bus(1, 0, timer_pwm_pkg::REG_CTRL, 32'h100 | (pre << 5) | (dir << 3));
      kick(0);
      wait_ev(4);
      check(evq[3] - evq[2], (dir == 2 ? 2 * per : per + 1) << pre);
    end
    // staged period stays out until terminal count
    bus(1, 0, timer_pwm_pkg::REG_CTRL, 0);
    bus(1, 0, timer_pwm_pkg::REG_PERIOD_BUF, 4);
    bus(0, 0, timer_pwm_pkg::REG_PERIOD, 0);
    check(q, per);
    bus(1, 0, timer_pwm_pkg::REG_CTRL, 32'h100);
    kick(0);
    wait_ev(2);
    bus(0, 0, timer_pwm_pkg::REG_PERIOD, 0);
    check(q, 4);
    bus(0, 0, timer_pwm_pkg::REG_PERIOD_BUF, 0);
    check(q, per);
    bus(0, 0, timer_pwm_pkg::REG_STATUS, 0);
    check(q & 1, 1);
    @(negedge clk);
    check(irq, 0);
    bus(1, 0, timer_pwm_pkg::REG_MASK, 1);
    @(negedge clk);
    check(irq, 1);
    bus(1, 0, timer_pwm_pkg::REG_CTRL, 0);
    bus(1, 0, timer_pwm_pkg::REG_STATUS, 3);
    @(negedge clk);
    check(irq, 0);
    bus(1, 1, timer_pwm_pkg::REG_CTRL, 32'h101);
    kick(1);
    cap_req[1] <= 1'b1;
    @(posedge clk);
    cap_req[1] <= 1'b0;
    bus(1, 1, timer_pwm_pkg::REG_MASK, 2);
    @(negedge clk);
    check(irq, 1);
    bus(0, 1, timer_pwm_pkg::REG_STATUS, 0);
    check(q & 2, 2);
    // plain pwm, then kill with main level high
    bus(1, 2, timer_pwm_pkg::REG_PERIOD, 9);
    bus(1, 2, timer_pwm_pkg::REG_CC, 3);
    bus(1, 2, timer_pwm_pkg::REG_CTRL, 32'h303);
    kick(2);
    repeat (20) @(posedge clk);
    pwm_cnt(2);
    check(hi, 3);
    check(hn, 7);
    check(hc, 1);
    @(posedge clk);
    kill[2] <= 1'b1;
    repeat (4) @(posedge clk);
    pwm_cnt(2);
    check(hi, 10);
    check(hn, 0);
    check(hc, 1);
    @(posedge clk);
    kill[2] <= 1'b0;
    // a stop edge freezes the counter; a running one would move in 23 cycles
    stop_req[2] <= 1'b1;
    @(posedge clk);
    stop_req[2] <= 1'b0;
    repeat (3) @(posedge clk);
    bus(0, 2, timer_pwm_pkg::REG_COUNT, 0);
    hi = q;
    repeat (20) @(posedge clk);
    bus(0, 2, timer_pwm_pkg::REG_COUNT, 0);
    check(q, hi);
    // dead-time pwm started on a falling start edge
    bus(1, 3, timer_pwm_pkg::REG_PERIOD, 9);
    bus(1, 3, timer_pwm_pkg::REG_CC, 5);
    bus(1, 3, timer_pwm_pkg::REG_TRIG, 32'h0c1);
    bus(1, 3, timer_pwm_pkg::REG_CTRL, 32'h0002_0105);
    start_req[3] <= 1'b1;
    repeat (20) @(posedge clk);
    bus(0, 3, timer_pwm_pkg::REG_COUNT, 0);
    check(q, 0);
    start_req[3] <= 1'b0;
    repeat (20) @(posedge clk);
    pwm_cnt(3);
    check(hi, 3);
    check(hn, 3);
    check(hc, 1);
    tally_and_finish();
  end
endmodule // timer_pwm_block_tb

/* File: timer_pwm_pkg.sv */
package timer_pwm_pkg;
  // ----------------------------------------
  // register word indexes inside a channel
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TRIG = 4'h1;
  localparam logic [3:0] REG_COUNT = 4'h2;
  localparam logic [3:0] REG_CC = 4'h3;
  localparam logic [3:0] REG_CC_BUF = 4'h4;
  localparam logic [3:0] REG_PERIOD = 4'h5;
  localparam logic [3:0] REG_PERIOD_BUF = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_MASK = 4'h8;
  // ----------------------------------------
  // reset values and layout
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [9:0] TRIG_RST = 10'h0c0;
  localparam logic [31:0] PERIOD_RST = 32'hffff_ffff;
  localparam logic [31:0] LFSR_RST = 32'h0000_0001;
  localparam int STATUS_TC_BIT = 0;
  localparam int STATUS_CC_BIT = 1;
  localparam int WIDE_BITS = 32;
  localparam int NARROW_BITS = 16;
  localparam int NUM_EVENTS = 5;

  typedef enum logic [2:0] {
    MODE_COMPARE, MODE_CAPTURE, MODE_QUAD, MODE_PWM, MODE_PRPWM, MODE_PWM_DT
  } mode_type;
  typedef enum logic [1:0] {DIR_UP, DIR_DOWN, DIR_UPDOWN} dir_type;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_LEVEL} edge_type;

  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] dead;
    logic [4:0] rsvd_lo;
    logic kill_n_lvl;
    logic kill_lvl;
    logic en;
    logic [2:0] pre;
    dir_type dir;
    mode_type mode;
  } ctrl_type;

  typedef struct packed {
    logic ovf;
    logic unf;
    logic cc;
    logic pwm;
    logic pwm_n;
  } chan_out_type;
endpackage
